// File: core/sac_ctl.sv
// converter control: apb registers, channel sequencing, result store
//
// How it works
// - the result is built bit by bit from msb to lsb over ten trials.
// - after the lsb the approximation word moves to the result store.
// - each result reads as 16 bits, value in bits 15:6, bits 5:0 zero.
// - every channel owns a result slot and gets only its own results.
// - result words are read-only; writes change nothing and error.
// - a per-channel byte view returns the upper 8 result bits.
// - the threshold is compared with that upper byte of each result.
// - the threshold is byte writable, readable, and reset to zero.
// - analog pins not in the selected set stay usable as inputs.
// - run bit written one starts conversion, written zero stops it.
// - mode 00 cont select, 01 cont scan, 10 one-shot select, 11 scan.
// - the active flag reads one while converting, zero when stopped.
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_ctl #(
    parameter int NCH        = 16,
    parameter int SAMPLE_CYC = `SAC_SAMPLE_CYC,
    parameter int SETTLE_CYC = `SAC_SETTLE_CYC
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             cmp_in,
    input  wire logic [NCH-1:0]   analog_input_pins,
    output logic      [9:0]       dac_code,
    output logic                  sample_hold,
    output logic      [3:0]       ch_sel,
    output logic      [NCH-1:0]   dig_in_en
);
    import sac_pkg::*;

    localparam int W   = `SAC_RES_W;
    localparam int CHW = 4;

    sac_cnv_if #(.W(W)) cnv ();

    // per channel result store
    logic [W-1:0]     res_q [NCH];

    logic             run_q;
    sac_mode_e        mode_q;
    logic [CHW-1:0]   chsel_q;
    logic [7:0]       thr_q;
    logic [CHW-1:0]   cur_ch_q;
    logic             start_q;
    logic             abort_q;
    logic             pf_q;
    logic [CHW-1:0]   pf_ch_q;
    logic             cmp_s1_q;
    logic             cmp_s2_q;
    logic [NCH-1:0]   pin_s1_q;
    logic [NCH-1:0]   pin_s2_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [9:0]       dac_q;
    logic             sh_q;
    logic [3:0]       ch_q;
    logic [NCH-1:0]   den_q;

    // which pins the current mode and channel select claim
    function automatic logic [NCH-1:0] sel_mask(
        input sac_mode_e      md,
        input logic [CHW-1:0] ch
    );
        logic [NCH-1:0] m;
        m = '0;
        for (int i = 0; i < NCH; i++)
        begin
            if (md[0])
                m[i] = (CHW'(i) <= ch);
            else
                m[i] = (CHW'(i) == ch);
        end
        return m;
    endfunction

    // the engine; the comparator level reaches it only after sync
    sac_sar #(
        .W          (W),
        .SAMPLE_CYC (SAMPLE_CYC),
        .SETTLE_CYC (SETTLE_CYC)
    ) u_sar (
        .pclk    (pclk),
        .presetn (presetn),
        .cnv     (cnv)
    );

    assign cnv.start  = start_q;
    assign cnv.abort  = abort_q;
    assign cnv.cmp_hi = cmp_s2_q;

    // two-stage sync of the comparator and the pin levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            cmp_s1_q <= cmp_in;
            cmp_s2_q <= cmp_s1_q;
            pin_s1_q <= analog_input_pins;
            pin_s2_q <= pin_s1_q;
        end
    end

    // apb decode; one wait state, writes land on the pready edge
    wire        acc_ph  = psel & penable;
    wire        wr_go   = acc_ph & pready_q & pwrite;
    wire        rd_cap  = acc_ph & ~pready_q;
    wire        al_ok   = (paddr[1:0] == 2'b00);
    wire [3:0]  idx     = paddr[5:2];
    wire        idx_ok  = ({1'b0, idx} < 5'(NCH));
    wire        hit_md  = (paddr == `SAC_ADDR_MODE);
    wire        hit_cs  = (paddr == `SAC_ADDR_CHSEL);
    wire        hit_th  = (paddr == `SAC_ADDR_THR);
    wire        hit_cp  = (paddr == `SAC_ADDR_CMP);
    wire        hit_pt  = (paddr == `SAC_ADDR_PORT);
    wire        hit_rw  = al_ok & idx_ok & (paddr[11:6] == `SAC_RES_PAGE);
    wire        hit_rh  = al_ok & idx_ok & (paddr[11:6] == `SAC_RESH_PAGE);
    wire        hit_ro  = hit_rw | hit_rh | hit_cp | hit_pt;
    wire        hit_any = hit_ro | hit_md | hit_cs | hit_th;
    wire        wr_lo   = wr_go & pstrb[0];
    wire        wr_md   = wr_lo & hit_md;
    wire        wr_cs   = wr_lo & hit_cs;
    wire        wr_th   = wr_lo & hit_th;

    // result views and the threshold compare of the newest result
    wire [W-1:0]    res_sel  = res_q[idx];
    wire [15:0]     res_word = {res_sel, 6'h00};
    wire [7:0]      res_high = res_sel[W-1:W-8];
    wire [7:0]      new_high = cnv.result[W-1:W-8];
    wire            new_pf   = (new_high >= thr_q);
    wire [NCH-1:0]  claim    = sel_mask(mode_q, chsel_q);

    // sequencing helpers
    wire            scan     = mode_q[0];
    wire            oneshot  = mode_q[1];
    wire            last_ch  = ~scan | (cur_ch_q == chsel_q);
    wire [CHW-1:0]  first_ch = scan ? '0 : chsel_q;
    wire            new_run  = pwdata[`SAC_RUN_BIT];
    wire [1:0]      new_md   = pwdata[`SAC_MD_HI:`SAC_MD_LO];
    wire [CHW-1:0]  new_first =
        new_md[0] ? '0 : (wr_cs ? pwdata[CHW-1:0] : chsel_q);

    // read mux
    logic [31:0] rd_data;
    logic        rd_err;
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (hit_md)
        begin
            rd_data[`SAC_RUN_BIT]             = run_q;
            rd_data[`SAC_MD_HI:`SAC_MD_LO]    = mode_q;
            rd_data[`SAC_ACT_BIT]             = run_q;
        end
        else if (hit_cs)
            rd_data[CHW-1:0] = chsel_q;
        else if (hit_th)
            rd_data[7:0] = thr_q;
        else if (hit_cp)
            rd_data[7:0] = {pf_ch_q, 3'h0, pf_q};
        else if (hit_pt)
            rd_data[NCH-1:0] = pin_s2_q & ~claim;
        else if (hit_rw)
            rd_data[15:0] = res_word;
        else if (hit_rh)
            rd_data[7:0] = res_high;
        else
            rd_err = 1'b1;
    end

    // bus answer; writes to read-only places error out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= rd_cap;
            pslverr_q <= rd_cap & (pwrite ? (hit_ro | ~hit_any)
                                          : rd_err);
            if (rd_cap & ~pwrite)
                prdata_q <= rd_data;
        end
    end

    // threshold and channel select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thr_q   <= `SAC_THR_RST;
            chsel_q <= '0;
        end
        else
        begin
            if (wr_th)
                thr_q <= pwdata[7:0];
            if (wr_cs)
                chsel_q <= pwdata[CHW-1:0];
        end
    end

    // finished words go only to the slot of the converted channel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NCH; i++)
                res_q[i] <= '0;
            pf_q    <= 1'b0;
            pf_ch_q <= '0;
        end
        else if (cnv.done & run_q)
        begin
            res_q[cur_ch_q] <= cnv.result;
            pf_q            <= new_pf;
            pf_ch_q         <= cur_ch_q;
        end
    end

    // run control and channel stepping; a later write overrides done
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q    <= 1'b0;
            mode_q   <= sac_mode_e'(`SAC_MODE_RST);
            cur_ch_q <= '0;
            start_q  <= 1'b0;
            abort_q  <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            if (cnv.done & run_q)
            begin
                if (last_ch & oneshot)
                    run_q <= 1'b0;
                else
                begin
                    start_q  <= 1'b1;
                    cur_ch_q <= last_ch ? first_ch
                                        : cur_ch_q + CHW'(1);
                end
            end
            if (wr_md)
            begin
                mode_q <= sac_mode_e'(new_md);
                run_q  <= new_run;
                if (!new_run)
                begin
                    abort_q <= 1'b1;
                    start_q <= 1'b0;
                end
                else if (!run_q)
                begin
                    start_q  <= 1'b1;
                    cur_ch_q <= new_first;
                end
            end
        end
    end

    // analog side outputs, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_q <= 10'h000;
            sh_q  <= 1'b0;
            ch_q  <= 4'h0;
            den_q <= '1;
        end
        else
        begin
            dac_q <= cnv.trial;
            sh_q  <= cnv.sampling;
            ch_q  <= cur_ch_q;
            den_q <= ~claim;  // unclaimed pins keep digital input
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign dac_code    = dac_q;
    assign sample_hold = sh_q;
    assign ch_sel      = ch_q;
    assign dig_in_en   = den_q;
endmodule

// File: shared/sac_map.svh
// register map, field positions and timing counts of the converter control
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// byte addresses on the register bus
`define SAC_ADDR_MODE   12'h000
`define SAC_ADDR_CHSEL  12'h004
`define SAC_ADDR_THR    12'h008
`define SAC_ADDR_CMP    12'h00c
`define SAC_ADDR_PORT   12'h010
// result pages: address bits 11:6, channel in bits 5:2
`define SAC_RES_PAGE    6'h01
`define SAC_RESH_PAGE   6'h02

// converter mode register fields
`define SAC_RUN_BIT     7
`define SAC_MD_HI       5
`define SAC_MD_LO       4
`define SAC_ACT_BIT     0

// reset values
`define SAC_THR_RST     8'h00
`define SAC_MODE_RST    2'h0

// result layout inside the 16-bit word
`define SAC_RES_W       10
`define SAC_RES_LSB     6

// timing
`define SAC_CLK_NS      4
`define SAC_SAMPLE_NS   200
`define SAC_SETTLE_NS   40
`define SAC_SAMPLE_CYC  ((`SAC_SAMPLE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_SETTLE_CYC  ((`SAC_SETTLE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)

`endif

// File: shared/sac_pkg.sv
// types shared by the converter control modules
package sac_pkg;

    // operation modes, encoded 00..11 in declaration order
    typedef enum logic [1:0]
    {
        SAC_CONT_SEL,
        SAC_CONT_SCAN,
        SAC_ONE_SEL,
        SAC_ONE_SCAN
    } sac_mode_e;

    // approximation engine states
    typedef enum logic [1:0]
    {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_TRIAL
    } sac_eng_e;

endpackage

// File: shared/sac_cnv_if.sv
// link between the sequencer and the approximation engine
`timescale 1ns/1ps
interface sac_cnv_if #(parameter int W = 10);
    logic         start;
    logic         abort;
    logic         cmp_hi;
    logic [W-1:0] trial;
    logic         sampling;
    logic         busy;
    logic         done;
    logic [W-1:0] result;

    modport ctl
    (
        output start,
        output abort,
        output cmp_hi,
        input  trial,
        input  sampling,
        input  busy,
        input  done,
        input  result
    );

    modport eng
    (
        input  start,
        input  abort,
        input  cmp_hi,
        output trial,
        output sampling,
        output busy,
        output done,
        output result
    );
endinterface

// File: core/sac_sar.sv
// successive approximation engine: sample, then one bit per trial
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_sar #(
    parameter int W          = `SAC_RES_W,
    parameter int SAMPLE_CYC = `SAC_SAMPLE_CYC,
    parameter int SETTLE_CYC = `SAC_SETTLE_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    sac_cnv_if.eng   cnv
);
    import sac_pkg::*;

    localparam int BW = $clog2(W);

    sac_eng_e       state_q;
    logic [7:0]     cnt_q;
    logic [BW-1:0]  bit_q;
    logic [W-1:0]   acc_q;
    logic [W-1:0]   res_q;
    logic           done_q;

    // current trial bit and the decided value of this step
    wire [W-1:0] bit_m  = W'(1) << bit_q;
    wire [W-1:0] kept   = cnv.cmp_hi ? acc_q : (acc_q & ~bit_m);
    wire         tick   = (cnt_q == 8'h00);

    // msb first, each trial held for the settle count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= SAC_IDLE;
            cnt_q   <= 8'h00;
            bit_q   <= '0;
            acc_q   <= '0;
            res_q   <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (cnv.abort)
            begin
                state_q <= SAC_IDLE;
                acc_q   <= '0;
            end
            else
            begin
                case (state_q)
                    SAC_IDLE:
                        if (cnv.start)
                        begin
                            state_q <= SAC_SAMPLE;
                            cnt_q   <= 8'(SAMPLE_CYC - 1);
                            acc_q   <= '0;
                        end
                    SAC_SAMPLE:
                        if (tick)
                        begin
                            state_q <= SAC_TRIAL;
                            bit_q   <= BW'(W - 1);
                            acc_q   <= W'(1) << (W - 1);
                            cnt_q   <= 8'(SETTLE_CYC - 1);
                        end
                        else
                            cnt_q <= cnt_q - 8'h01;
                    SAC_TRIAL:
                        if (!tick)
                            cnt_q <= cnt_q - 8'h01;
                        else if (bit_q == '0)
                        begin
                            // lsb decided: hand the word over
                            acc_q   <= kept;
                            res_q   <= kept;
                            done_q  <= 1'b1;
                            state_q <= SAC_IDLE;
                        end
                        else
                        begin
                            acc_q <= kept | (bit_m >> 1);
                            bit_q <= bit_q - BW'(1);
                            cnt_q <= 8'(SETTLE_CYC - 1);
                        end
                    default:
                        state_q <= SAC_IDLE;
                endcase
            end
        end
    end

    assign cnv.trial    = acc_q;
    assign cnv.sampling = (state_q == SAC_SAMPLE);
    assign cnv.busy     = (state_q != SAC_IDLE);
    assign cnv.done     = done_q;
    assign cnv.result   = res_q;
endmodule

// File: tb/sac_afe_model.sv
// behavioural analog front end: sample and hold plus comparator
`timescale 1ns/1ps
module sac_afe_model #(
    parameter int NCH = 16
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [9:0]        dac_code,
    input  wire logic              sample_hold,
    input  wire logic [3:0]        ch_sel,
    input  wire logic [NCH*10-1:0] levels,
    output logic                   cmp_in
);
    logic [9:0] held_q;

    // track the selected input while sampling, freeze it afterwards
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            held_q <= 10'h000;
        else if (sample_hold)
            held_q <= levels[ch_sel*10 +: 10];
    end

    // high when the held level is at or above the trial code
    assign cmp_in = (held_q >= dac_code);
endmodule

// File: tb/sac_ctl_asserts.sv
// port checker for the converter control
`timescale 1ns/1ps
module sac_ctl_asserts #(
    parameter int NCH = 16
)(
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic [11:0]    paddr,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic [9:0]     dac_code,
    input wire logic           sample_hold,
    input wire logic [3:0]     ch_sel,
    input wire logic [NCH-1:0] dig_in_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // bus answer timing and framing
    a_rdy_timing: assert property ($rose(penable) && psel |=> pready)
        else $error("pready missing after access edge");
    a_rdy_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_align: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    // result words and byte views
    a_ro_write: assert property (
        pready && pwrite && paddr[11:6] == 6'h01 |-> pslverr)
        else $error("result write not refused");
    a_res_low_zero: assert property (
        pready && !pwrite && !pslverr && paddr[11:6] == 6'h01
        |-> prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000)
        else $error("result word layout wrong");
    a_byte_view: assert property (
        pready && !pwrite && !pslverr && paddr[11:6] == 6'h02
        |-> prdata[31:8] == 24'h000000)
        else $error("byte view wider than eight bits");
    // conversion sequencing seen at the front end
    a_msb_first: assert property (
        $fell(sample_hold) |-> ##[0:4]
        (dac_code == 10'h200 || dac_code == 10'h000))
        else $error("first trial is not the top bit");
    a_ch_stable: assert property (
        sample_hold && $past(sample_hold) |-> $stable(ch_sel))
        else $error("channel moved while sampling");
    a_claim_conv: assert property (
        sample_hold |-> !dig_in_en[ch_sel])
        else $error("converted pin left as digital input");
endmodule

bind sac_ctl sac_ctl_asserts #(.NCH(NCH)) i_sac_ctl_asserts (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dac_code(dac_code),
    .sample_hold(sample_hold), .ch_sel(ch_sel), .dig_in_en(dig_in_en));

// File: tb/test_sac_ctl.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
module test_sac_ctl;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd_q;
    logic [3:0]   pstrb, ch_sel;
    logic         cmp_in, sample_hold, err_q;
    logic [15:0]  pins, dig_in_en;
    logic [9:0]   dac_code;
    logic [159:0] levels;
    int           num_errors, check_count;

    sac_ctl #(.NCH(16), .SAMPLE_CYC(4), .SETTLE_CYC(4)) i_sac_ctl (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_in(cmp_in), .analog_input_pins(pins),
        .dac_code(dac_code), .sample_hold(sample_hold),
        .ch_sel(ch_sel), .dig_in_en(dig_in_en));

    sac_afe_model #(.NCH(16)) i_sac_afe_model (
        .pclk(pclk), .presetn(presetn), .dac_code(dac_code),
        .sample_hold(sample_hold), .ch_sel(ch_sel), .levels(levels),
        .cmp_in(cmp_in));

    // distinct level per channel so a misrouted result shows
    function automatic logic [9:0] lv(input int i);
        return 10'(i * 61 + 17);
    endfunction

    // one apb transfer; waits for pready, only the watchdog ends a hang
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd_q);
    endtask

    // both result views of one channel
    task automatic res_chk(input int i, input logic [9:0] e);
        rd_chk(12'h040 + 12'(4 * i), {16'h0, e, 6'h00});
        rd_chk(12'h080 + 12'(4 * i), {24'h0, e[9:2]});
    endtask

    // poll the active flag; a stuck engine is left to the watchdog
    task automatic wait_idle();
        do
        begin
            xfer(1'b0, 12'h000, 32'h0);
        end
        while (rd_q[0] !== 1'b0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // hang guard: all tests need well under this span
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        pins = 16'hf0ff;
        num_errors = 0;
        check_count = 0;
        for (int i = 0; i < 16; i++)
            levels[i*10 +: 10] = lv(i);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(12'h008, 32'h0);
        rd_chk(12'h040, 32'h0);
        xfer(1'b1, 12'h008, 32'hffffff5a);
        rd_chk(12'h008, 32'h5a);
        xfer(1'b0, 12'h002, 32'h0);
        chk("misaligned err", 32'h1, 32'(err_q));
        xfer(1'b0, 12'h3f0, 32'h0);
        chk("unmapped err", 32'h1, 32'(err_q));
        $display("test reset and bus done");
        // one-shot scan over every channel
        xfer(1'b1, 12'h004, 32'hf);
        xfer(1'b1, 12'h000, 32'hb0);
        rd_chk(12'h000, 32'hb1);
        rd_chk(12'h010, 32'h0);
        wait_idle();
        rd_chk(12'h000, 32'h30);
        for (int i = 0; i < 16; i++)
        begin
            res_chk(i, lv(i));
        end
        xfer(1'b1, 12'h044, 32'hffffffff);
        chk("result write err", 32'h1, 32'(err_q));
        rd_chk(12'h044, {16'h0, lv(1), 6'h00});
        $display("test scan done");
        // one-shot select with threshold at and just above the byte
        for (int k = 0; k < 2; k++)
        begin
            xfer(1'b1, 12'h008, 32'(lv(3) >> 2) + 32'(k));
            xfer(1'b1, 12'h004, 32'h3);
            xfer(1'b1, 12'h000, 32'ha0);
            wait_idle();
            rd_chk(12'h00c, 32'h30 | 32'(k == 0));
        end
        chk("dig_in_en", 32'h0000fff7, 32'(dig_in_en));
        rd_chk(12'h010, 32'h0000f0f7);
        $display("test compare and pins done");
        // continuous modes keep running until run is written zero
        for (int md = 0; md < 2; md++)
        begin
            xfer(1'b1, 12'h004, 32'h1);
            // fresh levels, so a slot left from the scan cannot pass
            levels[0 +: 10] <= lv(md + 8);
            levels[10 +: 10] <= lv(md + 5);
            xfer(1'b1, 12'h000, 32'h80 | 32'(md << 4));
            repeat (300) @(posedge pclk);
            rd_chk(12'h000, 32'h81 | 32'(md << 4));
            xfer(1'b1, 12'h000, 32'(md << 4));
            rd_chk(12'h000, 32'(md << 4));
            res_chk(1, lv(md + 5));
            res_chk(0, lv(md == 0 ? 0 : 9));
        end
        $display("test continuous done");
        tally_and_finish();
    end
endmodule
